// ### flash_host_pkg.sv
package flash_host_pkg;

   // register offsets on the wishbone side (byte addresses)
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_RAW    = 8'h08;
   localparam logic [7:0] ADR_BASE   = 8'h0C;
   localparam logic [7:0] ADR_PAGES  = 8'h10;
   localparam logic [7:0] ADR_VISI   = 8'h14;

   // field positions
   localparam int CTRL_GO_BIT   = 0;
   localparam int CTRL_OP_LSB   = 1;
   localparam int CTRL_MASTER_CLEAR_PIN_BIT = 8;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;

   // values after reset
   localparam logic [7:0]  PAGES_RST = 8'h01;
   localparam logic [15:0] BASE_RST  = 16'h0000;

   // link control codes
   localparam logic [3:0] CODE_EXEC  = 4'h0; // execute_instruction_code
   localparam logic [3:0] CODE_SHOUT = 4'h1; // register_shift_out_code

   // link frame shape: 4 code bits then 24 payload or 8 idle + 16 read
   localparam int CODE_BITS  = 4;
   localparam int IDLE_CLKS  = 8;
   localparam int FRAME_BITS = 28;
   localparam logic [4:0] LAST_BIT   = 5'(FRAME_BITS - 1);
   localparam logic [4:0] READ_FIRST = 5'(CODE_BITS + IDLE_CLKS);
   localparam logic [4:0] CODE_END   = 5'(CODE_BITS);

   // nv control word and erase stepping
   localparam int          WR_BIT    = 15;
   localparam logic [15:0] PAGE_STEP = 16'h0400;

   // erase sequence step indices
   localparam logic [4:0] ST_ADDR   = 5'h06;
   localparam logic [4:0] ST_POLL   = 5'h12;
   localparam logic [4:0] ST_REGISTER_SHIFT_OUT_CODE = 5'h17;
   localparam logic [4:0] ST_PEND   = 5'h18;
   localparam logic [4:0] ST_END    = 5'h1A;

   // timing: system clock period and exit hold time
   localparam int CLK_PERIOD_NS = 100;
   localparam int P16_NS        = 1000;
   localparam int P16_CYC       = (P16_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LINK_HALF_CYC = 5;

   typedef enum logic [2:0] {
      OP_EXEC,
      OP_READ,
      OP_ERASE,
      OP_EXIT
   } op_type;

endpackage

// ### link_shifter.sv
`timescale 1ns/1ps
module link_shifter
   import flash_host_pkg::*;
#(
   parameter int HALF = LINK_HALF_CYC
) (
   input  wire logic        i_clk,     // system clock
   input  wire logic        i_rst_n,   // synced reset, active low
   input  wire logic        i_start,   // one-cycle frame request
   input  wire logic        i_is_rd,   // frame is a shift-out
   input  wire logic [23:0] i_payload, // instruction to execute
   output logic             o_busy,    // frame in progress
   output logic             o_done,    // one-cycle end of frame
   output logic [15:0]      o_rdata,   // word clocked in
   output logic             o_sclk,    // serial clock pin
   input  wire logic        i_sd,      // serial data pin in
   output logic             o_sd,      // serial data pin out
   output logic             o_sd_oe    // serial data drive enable
);

   typedef struct packed {
      logic        s1;
      logic        s2;
      logic        busy;
      logic        done;
      logic        rd;
      logic        clk;
      logic        dout;
      logic        oe;
      logic [15:0] cnt;
      logic [4:0]  bitn;
      logic [27:0] sh;
      logic [15:0] data;
   } sh_type;

   sh_type q, d;

   // bit engine: data changes with clock low, read sampled at fall
   always_comb begin
      d      = q;
      d.s1   = i_sd;
      d.s2   = q.s1;
      d.done = 1'b0;
      if (!q.busy) begin
         if (i_start) begin
            d.busy = 1'b1;
            d.rd   = i_is_rd;
            d.sh   = {i_payload, i_is_rd ? CODE_SHOUT : CODE_EXEC};
            d.dout = d.sh[0];
            d.oe   = 1'b1;
            d.bitn = '0;
            d.cnt  = '0;
            d.clk  = 1'b0;
         end
      end else if (q.cnt == 16'(HALF - 1)) begin
         d.cnt = '0;
         if (!q.clk) begin
            d.clk = 1'b1;
         end else begin
            d.clk = 1'b0;
            if (q.rd && q.bitn >= READ_FIRST) begin
               d.data = {q.s2, q.data[15:1]};
            end
            if (q.bitn == LAST_BIT) begin
               d.busy = 1'b0;
               d.done = 1'b1;
               d.dout = 1'b0;
               d.oe   = 1'b1;
            end else begin
               d.bitn = q.bitn + 5'd1;
               d.sh   = {1'b0, q.sh[27:1]};
               d.dout = q.sh[1];
               d.oe   = !q.rd || (d.bitn < CODE_END);
            end
         end
      end else begin
         d.cnt = q.cnt + 16'd1;
      end
   end

   // state register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q    <= '0;
         q.oe <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign o_busy  = q.busy;
   assign o_done  = q.done;
   assign o_rdata = q.data;
   assign o_sclk  = q.clk;
   assign o_sd    = q.dout;
   assign o_sd_oe = q.oe;

endmodule

// ### flash_host_ctrl.sv
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module flash_host_ctrl
   import flash_host_pkg::*;
#(
   parameter int HALF = LINK_HALF_CYC
) (
   input  wire logic        I_CLK_SYS,   // system clock
   input  wire logic        I_RSTN,      // async reset, active low
   input  wire logic        I_WB_CYC,    // wishbone cycle
   input  wire logic        I_WB_STB,    // wishbone strobe
   input  wire logic        I_WB_WE,     // wishbone write
   input  wire logic [7:0]  I_WB_ADR,    // wishbone byte address
   input  wire logic [3:0]  I_WB_SEL,    // wishbone byte enables
   input  wire logic [31:0] I_WB_DAT,    // wishbone write data
   output logic [31:0]      O_WB_DAT,    // wishbone read data
   output logic             O_WB_ACK,    // wishbone acknowledge
   output logic             O_SCLK,      // prog_serial_clock pin
   input  wire logic        I_SDATA,     // prog_serial_data pin in
   output logic             O_SDATA,     // prog_serial_data pin out
   output logic             O_SDATA_OE,  // prog_serial_data drive enable
   output logic             O_MASTER_CLEAR_PIN       // master_clear_pin high level
);

   typedef enum logic [1:0] {
      S_IDLE,
      S_ISSUE,
      S_WAIT,
      S_EXIT
   } fsm_type;

   typedef struct packed {
      fsm_type     st;
      op_type      op;
      logic        master_clear_pin;
      logic        done;
      logic [23:0] raw;
      logic [15:0] base;
      logic [7:0]  pages;
      logic [15:0] visi;
      logic [4:0]  idx;
      logic [15:0] addr;
      logic [7:0]  left;
      logic [15:0] wcnt;
      logic        start;
      logic        ack;
      logic [31:0] rdat;
   } st_type;

   st_type q, d;

   logic        rst_meta;
   logic        rst_n;
   logic        sh_busy;
   logic        sh_done;
   logic [15:0] sh_rdata;
   logic        cur_rd;
   logic [23:0] cur_word;
   logic        wb_req;
   logic        wb_wr;

   // build a literal move into a working register
   function automatic logic [23:0] mov_lit(input logic [15:0] lit,
                                           input logic [3:0]  rn);
      mov_lit = {4'h2, lit, rn};
   endfunction

   // erase sequence table: returns shift-out flag and instruction
   function automatic logic [24:0] rom_word(input logic [4:0]  i,
                                            input logic [15:0] a);
      case (i)
         5'h00: rom_word = {1'b0, 24'h00_0000};
         5'h01: rom_word = {1'b0, 24'h04_0200};
         5'h02: rom_word = {1'b0, 24'h00_0000};
         5'h03: rom_word = {1'b0, 24'h00_0000};
         5'h04: rom_word = {1'b0, 24'h24_0030}; // page-erase code
         5'h05: rom_word = {1'b0, 24'h88_3B00};
         5'h06: rom_word = {1'b0, mov_lit(a, 4'h4)};
         5'h07: rom_word = {1'b0, 24'h88_3B14};
         5'h08: rom_word = {1'b0, 24'h20_0800}; // executive region
         5'h09: rom_word = {1'b0, 24'h88_3B20};
         5'h0A: rom_word = {1'b0, 24'h20_0550}; // key 0x55
         5'h0B: rom_word = {1'b0, 24'h88_3B30};
         5'h0C: rom_word = {1'b0, 24'h20_0AA0}; // key 0xAA
         5'h0D: rom_word = {1'b0, 24'h88_3B30};
         5'h0E: rom_word = {1'b0, 24'hA8_E761}; // set write-start
         5'h0F: rom_word = {1'b0, 24'h00_0000};
         5'h10: rom_word = {1'b0, 24'h00_0000};
         5'h11: rom_word = {1'b0, 24'h00_0000};
         5'h12: rom_word = {1'b0, 24'h04_0200}; // poll loop start
         5'h13: rom_word = {1'b0, 24'h00_0000};
         5'h14: rom_word = {1'b0, 24'h80_3B02};
         5'h15: rom_word = {1'b0, 24'h88_3C22};
         5'h16: rom_word = {1'b0, 24'h00_0000};
         5'h17: rom_word = {1'b1, 24'h00_0000}; // shift out control
         5'h18: rom_word = {1'b0, 24'h00_0000};
         5'h19: rom_word = {1'b0, 24'h20_0000}; // clear write enable
         5'h1A: rom_word = {1'b0, 24'h88_3B00};
         default: rom_word = {1'b0, 24'h00_0000};
      endcase
   endfunction

   // reset release through two flops
   always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // frame contents for the serial engine
   always_comb begin
      cur_rd   = 1'b0;
      cur_word = q.raw;
      case (q.op)
         OP_EXEC: begin // config or packed executive words
            cur_rd   = 1'b0;
            cur_word = q.raw;
         end
         OP_READ: begin // readback word or checksum data
            cur_rd   = 1'b1;
            cur_word = '0;
         end
         OP_ERASE: begin // erase, run before any executive load
            {cur_rd, cur_word} = rom_word(q.idx, q.addr);
         end
         default: begin
            cur_rd   = 1'b0;
            cur_word = q.raw;
         end
      endcase
   end

   assign wb_req = I_WB_CYC && I_WB_STB && !q.ack;
   assign wb_wr  = wb_req && I_WB_WE;

   // bus slave, register file and sequencer
   always_comb begin
      d       = q;
      d.start = 1'b0;
      d.ack   = wb_req;
      // register read, unmapped reads zero
      if (wb_req && !I_WB_WE) begin
         case (I_WB_ADR)
            ADR_CTRL: begin
               d.rdat = '0;
               d.rdat[CTRL_OP_LSB +: 3] = q.op;
               d.rdat[CTRL_MASTER_CLEAR_PIN_BIT]    = q.master_clear_pin;
            end
            ADR_STATUS: begin
               d.rdat = '0;
               d.rdat[STAT_BUSY_BIT] = (q.st != S_IDLE);
               d.rdat[STAT_DONE_BIT] = q.done;
            end
            ADR_RAW:   d.rdat = {8'h00, q.raw};
            ADR_BASE:  d.rdat = {16'h0000, q.base};
            ADR_PAGES: d.rdat = {24'h00_0000, q.pages};
            ADR_VISI:  d.rdat = {16'h0000, q.visi};
            default:   d.rdat = '0;
         endcase
      end
      // register write, done flag clears by writing one
      if (wb_wr) begin
         case (I_WB_ADR)
            ADR_CTRL: begin
               if (I_WB_SEL[1] && I_WB_DAT[CTRL_MASTER_CLEAR_PIN_BIT]) begin
                  d.master_clear_pin = 1'b1; // lowering only via exit op
               end
               if (I_WB_SEL[0] && I_WB_DAT[CTRL_GO_BIT] && q.st == S_IDLE) begin
                  d.op    = op_type'(I_WB_DAT[CTRL_OP_LSB +: 3]);
                  d.st    = (d.op == OP_EXIT) ? S_EXIT : S_ISSUE;
                  d.idx   = '0;
                  d.addr  = q.base;
                  d.left  = q.pages;
                  d.wcnt  = '0;
               end
            end
            ADR_STATUS: begin
               if (I_WB_SEL[0] && I_WB_DAT[STAT_DONE_BIT]) begin
                  d.done = 1'b0;
               end
            end
            ADR_RAW: begin
               if (I_WB_SEL[0]) d.raw[7:0]   = I_WB_DAT[7:0];
               if (I_WB_SEL[1]) d.raw[15:8]  = I_WB_DAT[15:8];
               if (I_WB_SEL[2]) d.raw[23:16] = I_WB_DAT[23:16];
            end
            ADR_BASE: begin // first page erased, keep page one out
               if (I_WB_SEL[0]) d.base[7:0]  = I_WB_DAT[7:0];
               if (I_WB_SEL[1]) d.base[15:8] = I_WB_DAT[15:8];
            end
            ADR_PAGES: begin
               if (I_WB_SEL[0]) d.pages = I_WB_DAT[7:0];
            end
            default: begin
            end
         endcase
      end
      // sequencer
      case (q.st)
         S_IDLE: begin
         end
         S_ISSUE: begin
            if (!sh_busy) begin
               d.start = 1'b1;
               d.st    = S_WAIT;
            end
         end
         S_WAIT: begin
            if (sh_done) begin
               if (cur_rd) begin
                  d.visi = sh_rdata;
               end
               if (q.op != OP_ERASE) begin
                  d.st   = S_IDLE;
                  d.done = 1'b1;
               end else if (q.idx == ST_PEND) begin
                  d.st = S_ISSUE;
                  if (q.visi[WR_BIT]) begin
                     d.idx = ST_POLL; // still writing, poll again
                  end else if (q.left > 8'd1) begin
                     d.left = q.left - 8'd1;
                     d.addr = q.addr + PAGE_STEP; // next page
                     d.idx  = ST_ADDR;
                  end else begin
                     d.idx = q.idx + 5'd1;
                  end
               end else if (q.idx == ST_END) begin
                  d.st   = S_IDLE;
                  d.done = 1'b1;
               end else begin
                  d.idx = q.idx + 5'd1;
                  d.st  = S_ISSUE;
               end
            end
         end
         S_EXIT: begin
            // hold after last link activity, then drop master clear
            if (sh_busy) begin
               d.wcnt = '0;
            end else if (q.wcnt == 16'(P16_CYC - 1)) begin
               d.master_clear_pin = 1'b0;
               d.st   = S_IDLE;
               d.done = 1'b1;
            end else begin
               d.wcnt = q.wcnt + 16'd1;
            end
         end
         default: d.st = S_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         q       <= '0;
         q.st    <= S_IDLE;
         q.op    <= OP_EXEC;
         q.pages <= PAGES_RST;
         q.base  <= BASE_RST;
      end else begin
         q <= d;
      end
   end

   // serial engine at the programming pins
   link_shifter #(
      .HALF (HALF)
   ) u_shift (
      .i_clk     (I_CLK_SYS),
      .i_rst_n   (rst_n),
      .i_start   (q.start),
      .i_is_rd   (cur_rd),
      .i_payload (cur_word),
      .o_busy    (sh_busy),
      .o_done    (sh_done),
      .o_rdata   (sh_rdata),
      .o_sclk    (O_SCLK),
      .i_sd      (I_SDATA),
      .o_sd      (O_SDATA),
      .o_sd_oe   (O_SDATA_OE)
   );

   assign O_WB_DAT = q.rdat;
   assign O_WB_ACK = q.ack;
   assign O_MASTER_CLEAR_PIN   = q.master_clear_pin;

endmodule

// ### flash_host_monitor.sv
`timescale 1ns/1ps
module flash_host_monitor
   import flash_host_pkg::*;
#(
   parameter int HALF = LINK_HALF_CYC
) (
   input wire logic        I_CLK_SYS,  // system clock
   input wire logic        I_RSTN,     // async reset, active low
   input wire logic        I_WB_CYC,   // wishbone cycle
   input wire logic        I_WB_STB,   // wishbone strobe
   input wire logic        I_WB_WE,    // wishbone write
   input wire logic [7:0]  I_WB_ADR,   // wishbone address
   input wire logic [3:0]  I_WB_SEL,   // wishbone byte enables
   input wire logic [31:0] I_WB_DAT,   // wishbone write data
   input wire logic        O_WB_ACK,   // wishbone acknowledge
   input wire logic        O_SCLK,     // serial clock pin
   input wire logic        O_SDATA,    // serial data out
   input wire logic        O_SDATA_OE, // serial data enable
   input wire logic        O_MASTER_CLEAR_PIN      // master clear level
);
   logic [7:0] run_q;   // samples the clock level has held
   logic [7:0] quiet_q; // samples since last pin activity
   logic       sclk_q;
   logic       sd_q;
   logic       oe_q;

   // level and activity counters, saturating so long idles stay valid
   always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
         run_q   <= 8'hFF;
         quiet_q <= 8'hFF;
         sclk_q  <= 1'b0;
         sd_q    <= 1'b0;
         oe_q    <= 1'b1;
      end else begin
         sclk_q <= O_SCLK;
         sd_q   <= O_SDATA;
         oe_q   <= O_SDATA_OE;
         if (O_SCLK != sclk_q) run_q <= 8'h01;
         else if (run_q != 8'hFF) run_q <= run_q + 8'h01;
         if (O_SCLK != sclk_q || O_SDATA != sd_q || O_SDATA_OE != oe_q)
            quiet_q <= 8'h00;
         else if (quiet_q != 8'hFF) quiet_q <= quiet_q + 8'h01;
      end
   end

   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RSTN);

   AST_ACK_ONE:
      assert property ((I_WB_CYC && I_WB_STB && !O_WB_ACK) |=> O_WB_ACK)
      else $error("ack missing one cycle after request");
   AST_NO_SPURIOUS_ACK:
      assert property (O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB))
      else $error("ack without request");
   AST_RESET_OUTS:
      assert property ($past(!I_RSTN) |-> (!O_SCLK && !O_MASTER_CLEAR_PIN && O_SDATA_OE))
      else $error("pins not at reset level after reset");
   AST_SCLK_HIGH:
      assert property ($fell(O_SCLK) |-> run_q == 8'(HALF))
      else $error("serial clock high time wrong");
   AST_SCLK_LOW:
      assert property ($rose(O_SCLK) |-> run_q >= 8'(HALF))
      else $error("serial clock low time short");
   AST_DATA_STABLE:
      assert property ((O_SCLK && $past(O_SCLK)) |->
                       ($stable(O_SDATA) && $stable(O_SDATA_OE)))
      else $error("serial data moved while clock high");
   AST_EXIT_HOLD:
      assert property ($fell(O_MASTER_CLEAR_PIN) |->
                       (quiet_q >= 8'(P16_CYC - 1)) && !O_SCLK)
      else $error("master clear dropped too soon");
   AST_MASTER_CLEAR_PIN_SET:
      assert property ((I_WB_CYC && I_WB_STB && I_WB_WE && !O_WB_ACK &&
                        I_WB_ADR == ADR_CTRL && I_WB_SEL[1] &&
                        I_WB_DAT[CTRL_MASTER_CLEAR_PIN_BIT]) |-> ##[1:3] O_MASTER_CLEAR_PIN)
      else $error("master clear not raised");
endmodule

bind flash_host_ctrl flash_host_monitor #(.HALF(HALF)) u_mon (
   .I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_WB_CYC(I_WB_CYC),
   .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
   .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_ACK(O_WB_ACK),
   .O_SCLK(O_SCLK), .O_SDATA(O_SDATA), .O_SDATA_OE(O_SDATA_OE),
   .O_MASTER_CLEAR_PIN(O_MASTER_CLEAR_PIN)
);

// ### flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model (
   input  wire logic i_sclk, // prog_serial_clock from host
   input  wire logic i_master_clear_pin, // master_clear_pin level
   input  wire logic i_sd,   // resolved serial data line
   output logic      o_sd    // device side of the data line
);
   logic [4:0]  bit_q;
   logic [3:0]  code_q;
   logic [23:0] ins_q;
   logic [23:0] last_ins;
   logic [15:0] w0_q, w4_q, nvcon_q, adr_lo_q, adr_hi_q, key_q, visi_q;
   logic [15:0] erased [0:7];
   logic [1:0]  busy_q;
   logic        drv_q;
   logic        dout_q = 1'b0;
   int exec_cnt = 0, read_cnt = 0, erase_cnt = 0, poll_cnt = 0, bad_cnt = 0;

   // released line shows the inverse of the last driven bit
   assign o_sd = drv_q ? dout_q : ~dout_q;

   // executes one frame; literal moves and control register writes land here
   task automatic execute(input logic [23:0] ins);
      last_ins <= ins;
      exec_cnt++;
      if (ins[23:20] == 4'h2 && ins[3:0] == 4'h0) w0_q <= ins[19:4];
      if (ins[23:20] == 4'h2 && ins[3:0] == 4'h4) w4_q <= ins[19:4];
      case (ins)
         24'h88_3B00: nvcon_q <= w0_q;
         24'h88_3B14: adr_lo_q <= w4_q;
         24'h88_3B20: adr_hi_q <= w0_q;
         24'h88_3B30: key_q <= {key_q[7:0], w0_q[7:0]};
         24'hA8_E761: if (key_q == 16'h55AA) begin
            nvcon_q[15] <= 1'b1;
            busy_q <= 2'h2;
            erased[erase_cnt[2:0]] <= adr_lo_q;
            if (nvcon_q != 16'h4003 || adr_hi_q != 16'h0080)
               bad_cnt++;
            erase_cnt++;
            key_q <= 16'h0000;
         end
         24'h88_3C22: begin
            visi_q <= nvcon_q;
            poll_cnt++;
            if (busy_q != 2'h0) busy_q <= busy_q - 2'h1;
            if (busy_q == 2'h1) nvcon_q[15] <= 1'b0;
         end
         default: ;
      endcase
   endtask

   // frame decoder, sampled on the rising serial clock
   always @(posedge i_sclk or negedge i_master_clear_pin) begin
      if (!i_master_clear_pin) begin
         bit_q <= 5'h00;
         drv_q <= 1'b0;
         key_q <= 16'h0000;
         nvcon_q <= 16'h0000;
         busy_q <= 2'h0;
         visi_q <= 16'hA5C3;
      end else begin
         bit_q <= (bit_q == 5'h1B) ? 5'h00 : bit_q + 5'h01;
         if (bit_q < 5'h04) code_q[bit_q[1:0]] <= i_sd;
         else if (code_q == 4'h0) ins_q[bit_q - 5'h04] <= i_sd;
         if (bit_q == 5'h1B && code_q == 4'h0)
            execute({i_sd, ins_q[22:0]});
         if (bit_q == 5'h1B && code_q == 4'h1) read_cnt++;
         drv_q <= (code_q == 4'h1 && bit_q >= 5'h0C);
         if (code_q == 4'h1 && bit_q >= 5'h0C)
            dout_q <= visi_q[bit_q - 5'h0C];
      end
   end
endmodule

// ### test_executive_flash_program_sequencer.sv
`timescale 1ns/1ps
module test_executive_flash_program_sequencer;
   import flash_host_pkg::*;
   typedef struct {
      logic        we;
      logic [7:0]  adr;
      logic [31:0] dat;
      logic [31:0] exp;
   } row_type;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic        ack, sclk, sdo, soe, master_clear_pin, dev_sd, sd_line;
   int          err_count = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   row_type     rows [0:10];

   always #50 clk = ~clk;

   // host drives the data line while its enable is set, the device otherwise
   assign sd_line = soe ? sdo : dev_sd;

   flash_host_ctrl #(.HALF(4)) u_dut (
      .I_CLK_SYS(clk), .I_RSTN(rstn), .I_WB_CYC(cyc), .I_WB_STB(stb),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
      .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_SCLK(sclk), .I_SDATA(sd_line),
      .O_SDATA(sdo), .O_SDATA_OE(soe), .O_MASTER_CLEAR_PIN(master_clear_pin)
   );
   flash_dev_model u_dev (
      .i_sclk(sclk), .i_master_clear_pin(master_clear_pin), .i_sd(sd_line), .o_sd(dev_sd)
   );

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one classic wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1);
      check("bus ack latency", n, 2);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input string s);
      logic [31:0] q;
      wb(1'b0, a, 32'h0000_0000, q);
      check(s, q, e);
   endtask

   task automatic wait_done;
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         wb(1'b0, ADR_STATUS, 32'h0000_0000, q);
         n++;
      end while (q[STAT_DONE_BIT] !== 1'b1 && n < 30000);
      check("op done", q[STAT_DONE_BIT], 1);
      check("busy after done", q[STAT_BUSY_BIT], 0);
      wr(ADR_STATUS, 32'h0000_0002);
   endtask

   function automatic logic [31:0] mk(input op_type op, input logic m);
      return {23'h0, m, 4'h0, op, 1'b1};
   endfunction

   task automatic run_op(input logic [31:0] c);
      wr(ADR_CTRL, c);
      wait_done();
   endtask

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         err_count++;
         $display("ERROR watchdog expected finish seen timeout");
         tally_and_finish();
      end
   end

   initial begin
      logic [31:0] q;
      int n;
      rows = '{'{1'b0, ADR_STATUS, 32'h0, 32'h0},
         '{1'b0, ADR_BASE, 32'h0, 32'h0},
         '{1'b0, ADR_PAGES, 32'h0, 32'h1}, '{1'b0, ADR_VISI, 32'h0, 32'h0},
         '{1'b0, 8'h20, 32'h0, 32'h0}, '{1'b1, ADR_BASE, 32'h0800, 32'h0},
         '{1'b0, ADR_BASE, 32'h0, 32'h0800}, '{1'b1, ADR_PAGES, 32'h3, 32'h0},
         '{1'b0, ADR_PAGES, 32'h0, 32'h3}, '{1'b1, 8'h20, 32'hFFFF_FFFF, 32'h0},
         '{1'b0, 8'h20, 32'h0, 32'h0}};
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (rows[i]) begin
         if (rows[i].we) wr(rows[i].adr, rows[i].dat);
         else rd(rows[i].adr, rows[i].exp, "register read");
      end
      $display("test register table done");
      // reset in mid-run, inside a read frame with the line released
      wr(ADR_CTRL, mk(OP_READ, 1'b1));
      repeat (38) @(posedge clk);
      check("frame before reset", {sclk, soe}, 2'b10);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      check("reset sclk", sclk, 0);
      check("reset oe", soe, 1);
      check("reset master_clear_pin", master_clear_pin, 0);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(ADR_BASE, 32'h0000_0000, "base after reset");
      rd(ADR_PAGES, 32'h0000_0001, "pages after reset");
      $display("test mid-run reset done");
      wr(ADR_RAW, 32'h00AB_CDEF);
      n = u_dev.exec_cnt;
      run_op(mk(OP_EXEC, 1'b1));
      check("master_clear_pin held", master_clear_pin, 1);
      wr(ADR_CTRL, 32'h0000_0000);
      check("master_clear_pin kept", master_clear_pin, 1);
      check("exec instr", u_dev.last_ins, 32'h00AB_CDEF);
      check("exec frames", u_dev.exec_cnt - n, 1);
      rd(ADR_STATUS, 32'h0000_0000, "status cleared");
      $display("test exec done");
      // second start while busy must be dropped
      n = u_dev.exec_cnt;
      wr(ADR_CTRL, mk(OP_EXEC, 1'b1));
      wr(ADR_CTRL, mk(OP_EXEC, 1'b1));
      wait_done();
      check("go while busy", u_dev.exec_cnt - n, 1);
      $display("test busy start done");
      n = u_dev.read_cnt;
      run_op(mk(OP_READ, 1'b1));
      rd(ADR_VISI, 32'h0000_A5C3, "visi read");
      check("read frames", u_dev.read_cnt - n, 1);
      $display("test shift-out done");
      wr(ADR_BASE, 32'h0000_0800);
      wr(ADR_PAGES, 32'h0000_0003);
      run_op(mk(OP_ERASE, 1'b1));
      check("pages erased", u_dev.erase_cnt, 3);
      for (int i = 0; i < 3; i++) begin
         check("page addr", u_dev.erased[i], 32'h0800 + i * 32'h0400);
      end
      check("erase setup", u_dev.bad_cnt, 0);
      check("polls", u_dev.poll_cnt, 9);
      check("control cleared", u_dev.nvcon_q, 0);
      rd(ADR_VISI, 32'h0000_4003, "visi after poll");
      $display("test erase done");
      run_op(mk(OP_EXIT, 1'b1));
      check("master_clear_pin released", master_clear_pin, 0);
      $display("test exit done");
      tally_and_finish();
   end
endmodule
